/* cisel_pkg.sv */
// Shared constants and carrier types for the card interface select block.
// Assumes one 40 MHz clock and an 8-bit register port with 16-bit addresses.
package cisel_pkg;

  // ==========================================================================
  // Register port and addresses
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 8;
  localparam logic [15:0] SEL_ADDR     = 16'hfe00;
  localparam logic [15:0] CAUSE_ADDR   = 16'hfe01;
  localparam logic [15:0] IEN_ADDR     = 16'hfe02;
  localparam logic [15:0] SUPPLY_ADDR  = 16'hfe03;
  localparam logic [15:0] ICTL_ADDR    = 16'hfe04;
  localparam logic [15:0] ECTL_ADDR    = 16'hfe05;
  localparam logic [15:0] TXC_ADDR     = 16'hfe06;
  localparam logic [15:0] LEN_ADDR     = 16'hfe07;
  localparam logic [15:0] CLR_ADDR     = 16'hfe08;
  localparam logic [15:0] DIV_ADDR     = 16'hfe09;
  localparam logic [7:0]  RST_BYTE     = 8'h00;

  // ==========================================================================
  // Interface select fields
  localparam int          SEL_ROUTE_LSB  = 2;
  localparam int          SEL_BYPASS_BIT = 1;
  localparam int          ROUTE_INT_BIT  = 1;
  localparam logic [7:0]  SEL_WR_MASK    = 8'h0e;
  localparam logic [1:0]  ROUTE_NONE     = 2'h0;
  localparam logic [1:0]  ROUTE_EXT      = 2'h1;
  localparam int          IF_INT         = 0;
  localparam int          IF_EXT         = 1;

  // ==========================================================================
  // Cause, card control, transmit control and supply fields
  localparam int          CAUSE_LEN_BIT     = 7;
  localparam logic [7:0]  CAUSE_ROC_MASK    = 8'he4;
  localparam int          CTL_IO_OUT_BIT    = 0;
  localparam int          CTL_IO_DIR_BIT    = 1;
  localparam int          CTL_LVL_BIT       = 2;
  localparam int          CTL_STOP_BIT      = 3;
  localparam int          CTL_TXMODE_BIT    = 4;
  localparam int          CTL_IO_SAMPLE_BIT = 5;
  localparam logic [7:0]  CTL_WR_MASK       = 8'h1f;
  localparam int          TXC_SYNC_BIT      = 0;
  localparam int          TXC_DIRECT_BIT    = 7;
  localparam logic [7:0]  TXC_WR_MASK       = 8'h81;
  localparam int          SUPPLY_ON_BIT     = 0;
  localparam logic [7:0]  SUPPLY_WR_MASK    = 8'h01;

  // ==========================================================================
  // Card clock timing
  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          CARD_HALF_NS   = 100;
  localparam logic [7:0]  CARD_HALF_CYC  = 8'((CARD_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic clk;
    logic io_o;
    logic io_oe_n;
  } cisel_pin_s;

  typedef logic [6:0] cisel_ev_t;

endpackage

/* cisel_sync2.sv */
// Two-flop synchroniser for pin levels.
// Assumes the inputs come from outside the clk domain.
module cisel_sync2 #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import cisel_pkg::*;

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // ==========================================================================
  // Stages
  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '1;
      q_ff    <= '1;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule

/* cisel_clkgen.sv */
// Synchronous card clock generator with stop at a chosen level.
// Assumes half holds the half period in clk cycles; 0 acts as 1.
module cisel_clkgen (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic [7:0] half,
  input  wire logic       stop,
  input  wire logic       level,
  // Card clock and edge pulses
  output logic            card_clk,
  output logic            rise,
  output logic            fall
);
  import cisel_pkg::*;

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic       clk_ff;
  logic       nxt_clk;
  logic       park_ff;
  logic       nxt_park;
  logic       rise_ff;
  logic       nxt_rise;
  logic       fall_ff;
  logic       nxt_fall;
  logic       tick;

  assign tick = ({1'b0, cnt_ff} + 9'h001) >= {1'b0, half};

  // ==========================================================================
  // Divider and stop control
  // A stop completes the running phase, never truncates it
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_clk  = clk_ff;
    nxt_park = park_ff;
    nxt_rise = 1'b0;
    nxt_fall = 1'b0;
    if (!run) begin
      nxt_cnt  = 8'h00;
      nxt_clk  = 1'b0;
      nxt_park = 1'b0;
    end else if (park_ff) begin
      if (!stop) begin
        nxt_park = 1'b0;
        nxt_cnt  = 8'h00;
        // Restart from high drops low at once
        if (clk_ff) begin
          nxt_clk  = 1'b0;
          nxt_fall = 1'b1;
        end
      end
    end else if (tick) begin
      nxt_cnt = 8'h00;
      if (stop && clk_ff == level) begin
        nxt_park = 1'b1;
      end else begin
        nxt_clk  = !clk_ff;
        nxt_rise = !clk_ff;
        nxt_fall = clk_ff;
      end
    end else begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff  <= 8'h00;
      clk_ff  <= 1'b0;
      park_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      clk_ff  <= nxt_clk;
      park_ff <= nxt_park;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  assign card_clk = clk_ff;
  assign rise     = rise_ff;
  assign fall     = fall_ff;

endmodule

/* cisel_top.sv */
// Card interface select, bypass, interrupt cause and sync bit-length control.
// Assumes a one-cycle register strobe port and card pins outside the clk domain.
// Functional notes
// - Route field 00 gives no interface, 01 the external one, 1x the internal one.
// - Writing the route field never powers the card; only the supply register does.
// - With bypass set the UART leaves the IO path and the card control registers drive IO.
// - Reading the cause register clears its clear-on-read bits.
// - Each cause has an enable bit; a clear enable keeps that cause off the interrupt.
// - The cause register takes events only from the selected interface.
// - The direct IO mode bit sits at bit 7 of the transmit control register.
// - With direct IO mode off, sync IO is driven from the transmit FIFO output.
// - With direct IO mode on, sync IO is driven and read through the control registers, not the FIFO.
// - The bit-length counter counts falling card clock edges to a loaded 1..255, then raises its cause; 0 stops it.
// - In sync mode IO is sampled on the rising card clock edge and changes on the falling edge.
// - A cause bit still sets while its enable bit is clear.
module cisel_top (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // Register port
  input  wire logic [cisel_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [cisel_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [cisel_pkg::DATA_W-1:0]   reg_rdata,
  // Interrupt
  output logic                                card_irq,
  // Card UART
  input  wire logic                           uart_tx,
  output logic                                uart_rx,
  // Transmit FIFO
  input  wire logic                           tx_fifo_bit,
  output logic                                tx_fifo_shift,
  // Interface events
  input  wire cisel_pkg::cisel_ev_t           int_events,
  input  wire cisel_pkg::cisel_ev_t           ext_events,
  // Supply
  output logic                                card_supply_on,
  // Internal card pins
  output cisel_pkg::cisel_pin_s               int_pin,
  input  wire logic                           int_io_i,
  // External card pins
  output cisel_pkg::cisel_pin_s               external_card_io_pin,
  input  wire logic                           external_card_io_i
);
  import cisel_pkg::*;

  // ==========================================================================
  // State
  logic [7:0]  sel_ff, nxt_sel, ien_ff, nxt_ien, cause_ff, nxt_cause;
  logic [7:0]  supply_ff, nxt_supply, txc_ff, nxt_txc, div_ff, nxt_div;
  logic [7:0]  len_max_ff, nxt_len_max, len_cnt_ff, nxt_len_cnt;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        rx_ff, nxt_rx, shift_ff, nxt_shift;
  logic [7:0]  ctl_ff [2];
  logic [7:0]  nxt_ctl [2];
  logic [7:0]  ctl_rd [2];
  logic [1:0]  sample_ff, nxt_sample;
  cisel_pin_s  pin_ff [2];
  cisel_pin_s  nxt_pin [2];

  logic [1:0]  route, io_s, selected;
  logic        bypass, sync_mode, direct, run, len_active, len_hit;
  logic        card_clk, card_rise, card_fall, act_io;
  logic [7:0]  act_ctl, set, clr;
  cisel_ev_t   ev;
  logic        wr_sel, wr_ien, wr_sup, wr_ictl, wr_ectl, wr_txc, wr_len, wr_clr, wr_div, rd_cause;

  // ==========================================================================
  // Decode
  assign route      = sel_ff[SEL_ROUTE_LSB +: 2];
  assign bypass     = sel_ff[SEL_BYPASS_BIT];
  assign selected[IF_INT] = route[ROUTE_INT_BIT];
  assign selected[IF_EXT] = (route == ROUTE_EXT);
  assign sync_mode  = txc_ff[TXC_SYNC_BIT];
  assign direct     = txc_ff[TXC_DIRECT_BIT];
  assign act_ctl    = selected[IF_INT] ? ctl_ff[IF_INT] : ctl_ff[IF_EXT];
  assign act_io     = selected[IF_INT] ? io_s[IF_INT] : io_s[IF_EXT];
  assign run        = sync_mode && (route != ROUTE_NONE);
  assign len_active = (len_max_ff != 8'h00) && (len_cnt_ff != len_max_ff);

  localparam logic [15:0] SELECT_A = SEL_ADDR;
  assign wr_sel   = reg_wr && reg_addr == SELECT_A;
  assign wr_ien   = reg_wr && reg_addr == IEN_ADDR;
  assign wr_sup   = reg_wr && reg_addr == SUPPLY_ADDR;
  assign wr_ictl  = reg_wr && reg_addr == ICTL_ADDR;
  assign wr_ectl  = reg_wr && reg_addr == ECTL_ADDR;
  assign wr_txc   = reg_wr && reg_addr == TXC_ADDR;
  assign wr_len   = reg_wr && reg_addr == LEN_ADDR;
  assign wr_clr   = reg_wr && reg_addr == CLR_ADDR;
  assign wr_div   = reg_wr && reg_addr == DIV_ADDR;
  assign rd_cause = reg_rd && reg_addr == CAUSE_ADDR;

  cisel_sync2 #(
    .W (2)
  ) u_io_sync (
    .clk (clk),
    .rst (rst),
    .d   ({external_card_io_i, int_io_i}),
    .q   (io_s)
  );

  // Only the selected interface can have a running sync clock
  cisel_clkgen u_clkgen (
    .clk      (clk),
    .rst      (rst),
    .run      (run),
    .half     (div_ff),
    .stop     (act_ctl[CTL_STOP_BIT]),
    .level    (act_ctl[CTL_LVL_BIT]),
    .card_clk (card_clk),
    .rise     (card_rise),
    .fall     (card_fall)
  );

  // ==========================================================================
  // Registers, length counter, causes
  always_comb begin
    nxt_sel     = wr_sel ? (reg_wdata & SEL_WR_MASK) : sel_ff;
    nxt_ien     = wr_ien ? reg_wdata : ien_ff;
    // Card power follows its own register only
    nxt_supply  = wr_sup ? (reg_wdata & SUPPLY_WR_MASK) : supply_ff;
    nxt_txc     = wr_txc ? (reg_wdata & TXC_WR_MASK) : txc_ff;
    nxt_div     = wr_div ? reg_wdata : div_ff;
    nxt_len_max = wr_len ? reg_wdata : len_max_ff;
    nxt_len_cnt = len_cnt_ff;
    len_hit     = 1'b0;
    if (wr_len) begin
      nxt_len_cnt = 8'h00;
    end else if (sync_mode && card_fall && len_active) begin
      nxt_len_cnt = len_cnt_ff + 8'h01;
      len_hit     = (nxt_len_cnt == len_max_ff);
    end
    ev  = selected[IF_INT] ? int_events : (selected[IF_EXT] ? ext_events : '0);
    set = {len_hit, ev};
    clr = (rd_cause ? CAUSE_ROC_MASK : 8'h00) | (wr_clr ? reg_wdata : 8'h00);
    // New events win over a clear in the same cycle; enables never gate setting
    nxt_cause = (cause_ff & ~clr) | set;
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        SEL_ADDR:    nxt_rdata = sel_ff;
        CAUSE_ADDR:  nxt_rdata = cause_ff;
        IEN_ADDR:    nxt_rdata = ien_ff;
        SUPPLY_ADDR: nxt_rdata = supply_ff;
        ICTL_ADDR:   nxt_rdata = ctl_rd[IF_INT];
        ECTL_ADDR:   nxt_rdata = ctl_rd[IF_EXT];
        TXC_ADDR:    nxt_rdata = txc_ff;
        LEN_ADDR:    nxt_rdata = len_cnt_ff;
        DIV_ADDR:    nxt_rdata = div_ff;
        default:     nxt_rdata = 8'h00;
      endcase
    end
    nxt_rx    = (route == ROUTE_NONE || bypass) ? 1'b1 : act_io;
    nxt_shift = run && !bypass && !direct && card_fall && len_active;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_ff     <= RST_BYTE;
      ien_ff     <= RST_BYTE;
      cause_ff   <= RST_BYTE;
      supply_ff  <= RST_BYTE;
      txc_ff     <= RST_BYTE;
      div_ff     <= CARD_HALF_CYC;
      len_max_ff <= RST_BYTE;
      len_cnt_ff <= RST_BYTE;
      rdata_ff   <= RST_BYTE;
      rx_ff      <= 1'b1;
      shift_ff   <= 1'b0;
    end else begin
      sel_ff     <= nxt_sel;
      ien_ff     <= nxt_ien;
      cause_ff   <= nxt_cause;
      supply_ff  <= nxt_supply;
      txc_ff     <= nxt_txc;
      div_ff     <= nxt_div;
      len_max_ff <= nxt_len_max;
      len_cnt_ff <= nxt_len_cnt;
      rdata_ff   <= nxt_rdata;
      rx_ff      <= nxt_rx;
      shift_ff   <= nxt_shift;
    end
  end

  // ==========================================================================
  // Per-interface control register and pin drive
  for (genvar i = 0; i < 2; i++) begin : g_if
    logic ctl_wr;
    assign ctl_wr = (i == IF_INT) ? wr_ictl : wr_ectl;

    always_comb begin
      ctl_rd[i]                    = ctl_ff[i];
      ctl_rd[i][CTL_IO_SAMPLE_BIT] = sample_ff[i];
      nxt_ctl[i]    = ctl_wr ? (reg_wdata & CTL_WR_MASK) : ctl_ff[i];
      // Sync input is taken on the rising card edge only
      nxt_sample[i] = (selected[i] && sync_mode) ? (card_rise ? io_s[i] : sample_ff[i]) : io_s[i];
      nxt_pin[i]     = pin_ff[i];
      nxt_pin[i].clk = selected[i] && sync_mode && card_clk;
      if (!selected[i] || bypass || (sync_mode && direct)) begin
        nxt_pin[i].io_o    = ctl_ff[i][CTL_IO_OUT_BIT];
        nxt_pin[i].io_oe_n = !ctl_ff[i][CTL_IO_DIR_BIT];
      end else if (sync_mode) begin
        if (card_fall) begin
          nxt_pin[i].io_o    = tx_fifo_bit;
          nxt_pin[i].io_oe_n = !ctl_ff[i][CTL_TXMODE_BIT];
        end
      end else begin
        // Open-drain UART drive: pull low for a zero only
        nxt_pin[i].io_o    = 1'b0;
        nxt_pin[i].io_oe_n = uart_tx;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        ctl_ff[i]    <= RST_BYTE;
        sample_ff[i] <= 1'b1;
        pin_ff[i]    <= '{clk: 1'b0, io_o: 1'b0, io_oe_n: 1'b1};
      end else begin
        ctl_ff[i]    <= nxt_ctl[i];
        sample_ff[i] <= nxt_sample[i];
        pin_ff[i]    <= nxt_pin[i];
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata            = rdata_ff;
  assign card_irq             = |(cause_ff & ien_ff);
  assign uart_rx              = rx_ff;
  assign tx_fifo_shift        = shift_ff;
  assign card_supply_on       = supply_ff[SUPPLY_ON_BIT];
  assign int_pin              = pin_ff[IF_INT];
  assign external_card_io_pin = pin_ff[IF_EXT];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_len_last;
    sync_mode && card_fall && len_active && !wr_len && (len_cnt_ff + 8'h01 == len_max_ff);
  endsequence

  sequence s_int_uart;
    route[ROUTE_INT_BIT] && !bypass;
  endsequence

  a_route_none_rx: assert property ((route == ROUTE_NONE) |=> uart_rx)
    else $error("uart rx not idle with no interface");
  a_route_ext_io: assert property ((route == ROUTE_EXT) && !bypass && !sync_mode
    |=> external_card_io_pin.io_oe_n == $past(uart_tx))
    else $error("external io does not follow uart");
  a_supply_hold: assert property (wr_sel |=> $stable(card_supply_on))
    else $error("select write changed card supply");
  a_bypass_ctl: assert property (route[ROUTE_INT_BIT] && bypass
    |=> int_pin.io_o == $past(ctl_ff[IF_INT][CTL_IO_OUT_BIT]))
    else $error("bypass io not from control register");
  a_read_clear: assert property (rd_cause && set == 8'h00
    |=> (cause_ff & CAUSE_ROC_MASK) == 8'h00 && reg_rdata == $past(cause_ff))
    else $error("cause read did not clear");
  a_masked_quiet: assert property ((ien_ff == 8'h00) |-> !card_irq)
    else $error("irq with all enables clear");
  a_unsel_quiet: assert property ((route == ROUTE_NONE) && !len_hit && cause_ff == 8'h00
    |=> cause_ff == 8'h00)
    else $error("cause set with no interface selected");
  a_direct_bit7: assert property (wr_txc |=> direct == $past(reg_wdata[TXC_DIRECT_BIT]))
    else $error("direct io bit not at bit 7");
  a_fifo_drive: assert property (s_int_uart ##0 sync_mode && !direct && card_fall
    |=> int_pin.io_o == $past(tx_fifo_bit))
    else $error("sync io not from fifo on falling edge");
  a_direct_io: assert property (s_int_uart ##0 sync_mode && direct
    |=> int_pin.io_o == $past(ctl_ff[IF_INT][CTL_IO_OUT_BIT]))
    else $error("direct io not from control register");
  a_len_zero: assert property (len_max_ff == 8'h00 && !wr_len |=> len_cnt_ff == $past(len_cnt_ff))
    else $error("length counter moved while disabled");
  a_len_cause: assert property (s_len_last |=> cause_ff[CAUSE_LEN_BIT])
    else $error("length end did not set cause");
  a_sample_rise: assert property (selected[IF_INT] && sync_mode && card_rise
    |=> sample_ff[IF_INT] == $past(io_s[IF_INT]))
    else $error("io not sampled on rising card clock");
  a_len_irq: assert property (s_len_last ##0 ien_ff[CAUSE_LEN_BIT] && !wr_ien |=> card_irq)
    else $error("enabled cause did not raise irq");
  a_sel_reserved: assert property (wr_sel |=> (sel_ff & ~SEL_WR_MASK) == 8'h00)
    else $error("reserved select bits not zero");

endmodule

/* cisel_card_model.sv */
// Card model standing on one set of card pins.
// Assumes the block's pin struct and a pull-up on the IO line.
module cisel_card_model (
  // Pins from the block
  input  wire cisel_pkg::cisel_pin_s pin,
  // Card data
  input  wire logic                  en,
  input  wire logic                  bit_in,
  output logic                       io_i
);
  import cisel_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic shown = 1'b1;
  // ==========================================================================
  // Card output changes on the falling card clock
  always @(negedge pin.clk) shown <= bit_in;
  // Released line carries the card's bit while the card is enabled, else the pull-up level
  assign io_i = !pin.io_oe_n ? pin.io_o : (en ? shown : 1'b1);
endmodule

/* cisel_top_bench.sv */
// Self-checking bench for the card interface select block.
// Assumes card models on both pin sets and a 40 MHz clock.
module cisel_top_bench;
  import cisel_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, uart_tx = 1, tx_fifo_bit = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  cisel_ev_t   int_events = '0, ext_events = '0;
  logic        card_irq, uart_rx, tx_fifo_shift, card_supply_on, io_int, io_ext;
  logic        card_en = 0, card_bit = 1;
  cisel_pin_s  int_pin, ext_pin;
  int          fail_count = 0, total_checks = 0;
  cisel_top cisel_top_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_irq(card_irq),
    .uart_tx(uart_tx), .uart_rx(uart_rx), .tx_fifo_bit(tx_fifo_bit), .tx_fifo_shift(tx_fifo_shift),
    .int_events(int_events), .ext_events(ext_events), .card_supply_on(card_supply_on),
    .int_pin(int_pin), .int_io_i(io_int), .external_card_io_pin(ext_pin), .external_card_io_i(io_ext));
  cisel_card_model cisel_card_model_inst (.pin(int_pin), .en(card_en), .bit_in(card_bit), .io_i(io_int));
  cisel_card_model cisel_card_model_inst2 (.pin(ext_pin), .en(1'b0), .bit_in(card_bit), .io_i(io_ext));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ==========================================================================
  // Shared tasks
  task chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wrap_up;
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task t_regs;
    rd(SEL_ADDR, 8'h00);
    rd(CAUSE_ADDR, 8'h00);
    rd(16'hfe0f, 8'h00);
    wr(SEL_ADDR, 8'hff);
    rd(SEL_ADDR, 8'h0e);
    chk(card_supply_on, 1'b0);
    wr(SUPPLY_ADDR, 8'h01);
    wr(SEL_ADDR, 8'h0e);
    chk(card_supply_on, 1'b1);
  endtask
  task t_route;
    logic [1:0] r;
    uart_tx <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      r = 2'(i);
      wr(SEL_ADDR, {4'h0, r, 2'h0});
      wait_cyc(4);
      chk(int_pin.io_oe_n, !r[1]);
      chk(uart_rx, r == ROUTE_NONE);
      chk(ext_pin.io_oe_n, r != ROUTE_EXT);
    end
  endtask
  task t_bypass;
    wr(ECTL_ADDR, 8'h03);
    wr(SEL_ADDR, 8'h06);
    wait_cyc(4);
    chk(uart_rx, 1'b1);
    chk({ext_pin.io_o, ext_pin.io_oe_n}, 2'b10);
    uart_tx <= 1'b1;
  endtask
  task t_irq;
    wr(ECTL_ADDR, 8'h00);
    wr(SEL_ADDR, 8'h04);
    @(posedge clk);
    ext_events <= 7'h21;
    int_events <= 7'h40;
    @(posedge clk);
    ext_events <= '0;
    int_events <= '0;
    wait_cyc(1);
    chk(card_irq, 1'b0);
    wr(IEN_ADDR, 8'h20);
    wait_cyc(1);
    chk(card_irq, 1'b1);
    rd(CAUSE_ADDR, 8'h21);
    rd(CAUSE_ADDR, 8'h01);
    chk(card_irq, 1'b0);
    wr(CLR_ADDR, 8'h01);
    rd(CAUSE_ADDR, 8'h00);
  endtask
  task t_sync;
    int n;
    n = 0;
    tx_fifo_bit <= 1'b1;
    wr(TXC_ADDR, 8'h01);
    wr(SEL_ADDR, 8'h08);
    wr(ICTL_ADDR, 8'h10);
    wr(LEN_ADDR, 8'h02);
    repeat (80) begin
      wait_cyc(1);
      if (tx_fifo_shift === 1'b1) n++;
    end
    chk(8'(n), 8'h02);
    chk(int_pin.io_o, 1'b1);
    rd(CAUSE_ADDR, 8'h80);
    wr(TXC_ADDR, 8'h81);
    wr(ICTL_ADDR, 8'h12);
    wait_cyc(3);
    chk({int_pin.io_o, int_pin.io_oe_n}, 2'b00);
    card_en <= 1'b1;
    card_bit <= 1'b0;
    wr(ICTL_ADDR, 8'h10);
    wait_cyc(40);
    rd(ICTL_ADDR, 8'h10);
    card_bit <= 1'b1;
    wait_cyc(40);
    rd(ICTL_ADDR, 8'h30);
    card_en <= 1'b0;
  endtask
  task t_stop;
    wr(ICTL_ADDR, 8'h1e);
    wait_cyc(20);
    chk({int_pin.clk, int_pin.io_o, int_pin.io_oe_n}, 3'b100);
    wr(LEN_ADDR, 8'h01);
    wr(ICTL_ADDR, 8'h1f);
    wait_cyc(2);
    chk({int_pin.clk, int_pin.io_o, int_pin.io_oe_n}, 3'b110);
    wr(ICTL_ADDR, 8'h13);
    wait_cyc(2);
    chk({int_pin.clk, int_pin.io_o}, 2'b01);
    rd(CAUSE_ADDR, 8'h80);
  endtask
  initial begin
    wait_cyc(5);
    rst <= 1'b0;
    t_regs();
    t_route();
    t_bypass();
    t_irq();
    t_sync();
    t_stop();
    wrap_up();
  end
  // Watchdog far beyond the few hundred cycles the scenarios need
  initial begin
    #(25 * 20000);
    fail_count++;
    wrap_up();
  end
endmodule
